// ==== logic/vei_map.svh ====
// register offsets, field codes, reset values and sizes for the voice encoder i/o block
// included by the top design file only; definitions only
`ifndef VEI_MAP_SVH
`define VEI_MAP_SVH
`define VEI_OFF_CLK_SEL     8'h60
`define VEI_OFF_MIXER       8'h61
`define VEI_OFF_MON_WIDTH   8'h74
`define VEI_OFF_MODE_PIN    8'h7b
`define VEI_REG_W           20
`define VEI_MODE_RST        20'h00000
`define VEI_MON_RST         20'h00000
`define VEI_MIX_RST         20'h00000
`define VEI_CLK_RST         20'h00000
`define VEI_MODE_HIGH_BASE  5'h10
`define VEI_MODE_MAX        5'h06
`define VEI_CLK_FIX_24      20'h10000
`define VEI_CLK_FIX_12      20'h20000
`define VEI_CLK_FIX_6       20'h40000
`define VEI_MIX_STEREO      8'h00
`define VEI_MIX_SUM         8'h40
`define VEI_MIX_HALF        8'h41
`define VEI_MIX_QUART       8'h42
`define VEI_FIFO_DEPTH      32
`define VEI_BYTE_W          8
`endif

// ==== logic/vei_pkg.sv ====
// types shared by the voice encoder i/o block
// constants live in vei_map.svh
package vei_pkg;
    // converter clock output frequency codes
    typedef enum logic [2:0] {
        CK_24576 = 3'h0,
        CK_22579 = 3'h1,
        CK_12288 = 3'h2,
        CK_11290 = 3'h3,
        CK_6144  = 3'h4,
        CK_5645  = 3'h5
    } vei_clk_sel_type;
    typedef enum logic [1:0] {
        SR_8K   = 2'h0,
        SR_11K  = 2'h1,
        SR_16K  = 2'h2,
        SR_32K  = 2'h3
    } vei_rate_type;
    typedef enum logic [2:0] {
        RD_IDLE = 3'h1,
        RD_DRIVE = 3'h2,
        RD_DONE = 3'h4
    } vei_rd_state_type;
endpackage

// ==== logic/vei_fifo.sv ====
// synchronous fifo with valid/ready on both sides
// single clock; depth must be a power of two
`timescale 1ns/1ps
module vei_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             mclk_i,
    input  wire logic             nrst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wptr_reg;
    logic [AW:0]      wptr_next;
    logic [AW:0]      rptr_reg;
    logic [AW:0]      rptr_next;
    logic             push;
    logic             pop;

    assign in_ready_o  = (wptr_reg - rptr_reg) != (AW+1)'(DEPTH);
    assign out_valid_o = wptr_reg != rptr_reg;
    assign out_data_o  = mem[rptr_reg[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        wptr_next = push ? wptr_reg + (AW+1)'(1) : wptr_reg;
        rptr_next = pop ? rptr_reg + (AW+1)'(1) : rptr_reg;
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
        end
        if (push) begin
            mem[wptr_reg[AW-1:0]] <= in_data_i;
        end
    end
endmodule

// ==== logic/vei_serial_in.sv ====
// serial audio receiver on the link bit clock; hands stereo pairs over by toggle
// assumes the converter drives the bit clock and word strobe
`timescale 1ns/1ps
module vei_serial_in (
    input  wire logic        serial_in_bit_clock,
    input  wire logic        link_nrst_i,
    input  wire logic        serial_in_frame_strobe,
    input  wire logic        serial_in_sample_data,
    input  wire logic [5:0]  word_len_i,
    output logic [15:0]      left_o,
    output logic [15:0]      right_o,
    output logic             pair_toggle_o
);
    logic [31:0] shift_reg;
    logic [31:0] shift_next;
    logic [5:0]  cnt_reg;
    logic [5:0]  cnt_next;
    logic        ws_reg;
    logic        ws_next;
    logic [15:0] left_reg;
    logic [15:0] left_next;
    logic [15:0] right_reg;
    logic [15:0] right_next;
    logic        tog_reg;
    logic        tog_next;
    logic [15:0] word;

    // the lsb arrives with the strobe change, so the word is taken from shift_next
    always_comb begin
        word = 16'h0000;
        if (word_len_i == 6'd8) begin
            word = {shift_next[7:0], 8'h00};
        end else if (word_len_i == 6'd16) begin
            word = shift_next[15:0];
        end else begin
            word = shift_next[31:16];
        end
    end

    always_comb begin
        shift_next = {shift_reg[30:0], serial_in_sample_data};
        cnt_next   = (cnt_reg == 6'h3f) ? cnt_reg : cnt_reg + 6'h01;
        ws_next    = serial_in_frame_strobe;
        left_next  = left_reg;
        right_next = right_reg;
        tog_next   = tog_reg;
        if (ws_next != ws_reg) begin
            cnt_next = 6'h01;
            if (cnt_reg >= word_len_i) begin
                if (ws_reg) begin
                    right_next = word;
                    tog_next   = ~tog_reg;
                end else begin
                    left_next = word;
                end
            end
        end
    end

    always_ff @(posedge serial_in_bit_clock) begin
        if (!link_nrst_i) begin
            shift_reg <= 32'h00000000;
            cnt_reg   <= 6'h00;
            ws_reg    <= 1'b0;
            left_reg  <= 16'h0000;
            right_reg <= 16'h0000;
            tog_reg   <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            cnt_reg   <= cnt_next;
            ws_reg    <= ws_next;
            left_reg  <= left_next;
            right_reg <= right_next;
            tog_reg   <= tog_next;
        end
    end

    assign left_o        = left_reg;
    assign right_o       = right_reg;
    assign pair_toggle_o = tog_reg;
endmodule

// ==== logic/vei_top.sv ====
// voice encoder i/o and configuration block
// registers come from a write port fed by the control-bus slave;
// the serial link runs on the converter's bit clock.
`include "vei_map.svh"
`timescale 1ns/1ps
module vei_top (
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic        cfg_wr_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [19:0] cfg_data_i,
    input  wire logic        run_i,
    input  wire logic        clock_scaler_strap,
    input  wire logic [5:0]  sample_word_len_i,
    input  wire logic        serial_in_bit_clock,
    input  wire logic        link_nrst_i,
    input  wire logic        serial_in_frame_strobe,
    input  wire logic        serial_in_sample_data,
    input  wire logic        parallel_select_n,
    output logic             byte_waiting_n,
    output logic [3:0]       pio_lines_low_group_o,
    output logic [3:0]       pio_lines_low_group_oe_o,
    output logic [7:0]       pio_lines_high_group_o,
    output logic [7:0]       pio_lines_high_group_oe_o,
    output logic [1:0]       pio_mid_lines_o,
    output logic [1:0]       pio_mid_lines_oe_o,
    output logic [1:0]       pio_top_lines_o,
    output logic [1:0]       pio_top_lines_oe_o,
    output vei_pkg::vei_clk_sel_type converter_clock_out_sel_o,
    output logic             stereo_mode_o,
    output vei_pkg::vei_rate_type rate_o,
    output logic             monitor_16bit_o,
    output logic             frame_delay_en_o,
    output logic             sample_overrun_o
);
    // ==========
    // configuration registers
    logic [19:0] clk_sel_reg;
    logic [19:0] clk_sel_next;
    logic [19:0] mixer_reg;
    logic [19:0] mixer_next;
    logic [19:0] mon_reg;
    logic [19:0] mon_next;
    logic [19:0] mode_reg;
    logic [19:0] mode_next;

    always_comb begin
        clk_sel_next = clk_sel_reg;
        mixer_next   = mixer_reg;
        mon_next     = mon_reg;
        mode_next    = mode_reg;
        // no lockout while running: the controller is trusted to hold still
        if (cfg_wr_i) begin
            case (cfg_addr_i)
                `VEI_OFF_CLK_SEL:   clk_sel_next = cfg_data_i;
                `VEI_OFF_MIXER:     mixer_next   = cfg_data_i;
                `VEI_OFF_MON_WIDTH: mon_next     = cfg_data_i;
                `VEI_OFF_MODE_PIN:  mode_next    = cfg_data_i;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            clk_sel_reg <= `VEI_CLK_RST;
            mixer_reg   <= `VEI_MIX_RST;
            mon_reg     <= `VEI_MON_RST;
            mode_reg    <= `VEI_MODE_RST;
        end else begin
            clk_sel_reg <= clk_sel_next;
            mixer_reg   <= mixer_next;
            mon_reg     <= mon_next;
            mode_reg    <= mode_next;
        end
    end

    // ==========
    // mode decode
    logic [2:0] mode_low;
    logic       high_pins;

    assign high_pins = mode_reg[4];
    assign mode_low  = mode_reg[2:0];

    always_comb begin
        rate_o        = vei_pkg::SR_8K;
        stereo_mode_o = 1'b1;
        case (mode_low)
            3'h0: begin rate_o = vei_pkg::SR_8K;  stereo_mode_o = 1'b1; end
            3'h1: begin rate_o = vei_pkg::SR_8K;  stereo_mode_o = 1'b0; end
            3'h2: begin rate_o = vei_pkg::SR_11K; stereo_mode_o = 1'b1; end
            3'h3: begin rate_o = vei_pkg::SR_11K; stereo_mode_o = 1'b0; end
            3'h4: begin rate_o = vei_pkg::SR_16K; stereo_mode_o = 1'b1; end
            3'h5: begin rate_o = vei_pkg::SR_16K; stereo_mode_o = 1'b0; end
            3'h6: begin rate_o = vei_pkg::SR_32K; stereo_mode_o = 1'b0; end
            default: begin rate_o = vei_pkg::SR_8K; stereo_mode_o = 1'b1; end
        endcase
    end

    // ==========
    // converter clock selection
    // strap pin: three stages, sampled once at reset release
    logic [2:0] strap_sync_reg;
    logic       strap_reg;
    logic       strap_next;
    logic       rst_seen_reg;

    assign strap_next = rst_seen_reg ? strap_reg : strap_sync_reg[2];

    always_ff @(posedge mclk_i) begin
        strap_sync_reg <= {strap_sync_reg[1:0], clock_scaler_strap};
        if (!nrst_i) begin
            rst_seen_reg <= 1'b0;
            strap_reg    <= 1'b0;
        end else begin
            rst_seen_reg <= 1'b1;
            strap_reg    <= strap_next;
        end
    end

    always_comb begin
        converter_clock_out_sel_o = vei_pkg::CK_24576;
        if (clk_sel_reg == `VEI_CLK_FIX_24) begin
            converter_clock_out_sel_o = (rate_o == vei_pkg::SR_11K) ?
                vei_pkg::CK_22579 : vei_pkg::CK_24576;
        end else if (clk_sel_reg == `VEI_CLK_FIX_12) begin
            converter_clock_out_sel_o = (rate_o == vei_pkg::SR_11K) ?
                vei_pkg::CK_11290 : vei_pkg::CK_12288;
        end else if (clk_sel_reg == `VEI_CLK_FIX_6) begin
            converter_clock_out_sel_o = (rate_o == vei_pkg::SR_11K) ?
                vei_pkg::CK_5645 : vei_pkg::CK_6144;
        end else if (strap_reg) begin
            converter_clock_out_sel_o = (rate_o == vei_pkg::SR_11K) ?
                vei_pkg::CK_22579 : vei_pkg::CK_24576;
        end else begin
            case (rate_o)
                vei_pkg::SR_32K: converter_clock_out_sel_o = vei_pkg::CK_24576;
                vei_pkg::SR_16K: converter_clock_out_sel_o = vei_pkg::CK_12288;
                vei_pkg::SR_11K: converter_clock_out_sel_o = vei_pkg::CK_5645;
                vei_pkg::SR_8K:  converter_clock_out_sel_o = vei_pkg::CK_6144;
                default:         converter_clock_out_sel_o = vei_pkg::CK_6144;
            endcase
        end
    end

    assign monitor_16bit_o  = mon_reg[0];
    assign frame_delay_en_o = ~mon_reg[0];

    // ==========
    // serial input and crossing
    logic [15:0] left_l;
    logic [15:0] right_l;
    logic        tog_l;
    logic [2:0]  tog_sync_reg;
    logic        tog_seen_reg;
    logic        pair_evt;

    vei_serial_in u_sin (
        .serial_in_bit_clock    (serial_in_bit_clock),
        .link_nrst_i            (link_nrst_i),
        .serial_in_frame_strobe (serial_in_frame_strobe),
        .serial_in_sample_data  (serial_in_sample_data),
        .word_len_i             (sample_word_len_i),
        .left_o                 (left_l),
        .right_o                (right_l),
        .pair_toggle_o          (tog_l)
    );

    // words stay put for a frame, so reading them after the toggle is safe
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            tog_sync_reg <= 3'h0;
            tog_seen_reg <= 1'b0;
        end else begin
            tog_sync_reg <= {tog_sync_reg[1:0], tog_l};
            tog_seen_reg <= tog_sync_reg[2];
        end
    end
    assign pair_evt = (tog_sync_reg[2] == tog_sync_reg[1]) && (tog_sync_reg[2] != tog_seen_reg);

    // mono sources arrive on the left, right is ignored unless mixed
    function automatic logic [7:0] vei_mix(input logic [15:0] l, input logic [15:0] r,
                                           input logic [7:0] sel);
        logic [16:0] s;
        s = {l[15], l} + {r[15], r};
        case (sel)
            `VEI_MIX_SUM:   vei_mix = s[15:8];
            `VEI_MIX_HALF:  vei_mix = s[16:9];
            `VEI_MIX_QUART: vei_mix = {s[16], s[16:10]};
            default:        vei_mix = l[15:8];
        endcase
    endfunction

    // ==========
    // byte packer into the output buffer
    logic [7:0] enc_byte;
    logic       fifo_in_ready;
    logic [7:0] fifo_out_data;
    logic       fifo_out_valid;
    logic       fifo_pop;

    assign enc_byte = vei_mix(left_l, right_l, mixer_reg[7:0]);
    assign sample_overrun_o = pair_evt && run_i && !fifo_in_ready;

    vei_fifo #(
        .WIDTH (`VEI_BYTE_W),
        .DEPTH (`VEI_FIFO_DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .nrst_i      (nrst_i),
        .in_data_i   (enc_byte),
        .in_valid_i  (pair_evt && run_i),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_out_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_pop)
    );

    // ==========
    // parallel read handshake
    logic [2:0]  cs_sync_reg;
    logic        cs_low;
    vei_pkg::vei_rd_state_type rd_state_reg;
    vei_pkg::vei_rd_state_type rd_state_next;
    logic [7:0]  out_byte_reg;
    logic [7:0]  out_byte_next;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            cs_sync_reg <= 3'h7;
        end else begin
            cs_sync_reg <= {cs_sync_reg[1:0], parallel_select_n};
        end
    end
    // change counted only when stages two and three agree
    assign cs_low = (cs_sync_reg[2] == cs_sync_reg[1]) && !cs_sync_reg[2];

    always_comb begin
        rd_state_next = rd_state_reg;
        out_byte_next = out_byte_reg;
        fifo_pop      = 1'b0;
        case (rd_state_reg)
            vei_pkg::RD_IDLE: begin
                if (cs_low && fifo_out_valid) begin
                    out_byte_next = fifo_out_data;
                    fifo_pop      = 1'b1;
                    rd_state_next = vei_pkg::RD_DRIVE;
                end
            end
            vei_pkg::RD_DRIVE: begin
                if (cs_sync_reg[2] && cs_sync_reg[1]) begin
                    rd_state_next = vei_pkg::RD_IDLE;
                end
            end
            default: rd_state_next = vei_pkg::RD_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rd_state_reg <= vei_pkg::RD_IDLE;
            out_byte_reg <= 8'h00;
        end else begin
            rd_state_reg <= rd_state_next;
            out_byte_reg <= out_byte_next;
        end
    end

    assign byte_waiting_n = !(fifo_out_valid && rd_state_reg == vei_pkg::RD_IDLE);

    // ==========
    // pin routing
    logic drive;
    assign drive = (rd_state_reg == vei_pkg::RD_DRIVE);

    always_comb begin
        pio_lines_low_group_o     = 4'h0;
        pio_lines_low_group_oe_o  = 4'h0;
        pio_mid_lines_o           = 2'h0;
        pio_mid_lines_oe_o        = 2'h0;
        pio_top_lines_o           = 2'h0;
        pio_top_lines_oe_o        = 2'h0;
        pio_lines_high_group_o    = 8'h00;
        pio_lines_high_group_oe_o = 8'h00;
        if (high_pins) begin
            pio_lines_high_group_o    = out_byte_reg;
            pio_lines_high_group_oe_o = {8{drive}};
        end else begin
            pio_lines_low_group_o    = out_byte_reg[3:0];
            pio_lines_low_group_oe_o = {4{drive}};
            pio_mid_lines_o          = out_byte_reg[5:4];
            pio_mid_lines_oe_o       = {2{drive}};
            pio_top_lines_o          = out_byte_reg[7:6];
            pio_top_lines_oe_o       = {2{drive}};
        end
    end
endmodule

// ==== dv/vei_conv_model.sv ====
// converter model: i2s source driving the link bit clock
// bit clock runs only within frames; outside the words data toggles every clock, starting at the inverse of its last bit
`timescale 1ns/1ps
module vei_conv_model (
    output logic sclk_o,
    output logic ws_o,
    output logic sd_o
);
    initial begin
        {sclk_o, ws_o, sd_o} = 3'h0;
    end
    // ==========
    // one stereo pair of n-bit words (8, 16 or 32), left msb on the second clock, right msb one clock after the strobe rise
    task automatic send_pair(input logic [15:0] l, input logic [15:0] r, input int n);
        logic [63:0] w;
        w = {l, 16'h0, r, 16'h0};
        for (int i = 0; i < 2 * n + 4; i++) begin
            sclk_o = 1'b0;
            ws_o   = i >= n && i < 2 * n;
            sd_o   = (i >= 1 && i <= 2 * n) ? w[i <= n ? 64 - i : 32 + n - i] : ~sd_o;
            #6 sclk_o = 1'b1;
            #6;
        end
        sclk_o = 1'b0;
    endtask
endmodule

// ==== dv/vei_top_props.sv ====
// checker for the voice encoder i/o top
// sees top ports only; bound from the bench top
`timescale 1ns/1ps
module vei_top_props (
    input wire logic        mclk_i,
    input wire logic        nrst_i,
    input wire logic        cfg_wr_i,
    input wire logic [7:0]  cfg_addr_i,
    input wire logic [19:0] cfg_data_i,
    input wire logic        parallel_select_n,
    input wire logic        byte_waiting_n,
    input wire logic [3:0]  pio_lines_low_group_oe_o,
    input wire logic [7:0]  pio_lines_high_group_oe_o,
    input wire logic [1:0]  pio_mid_lines_oe_o,
    input wire logic [1:0]  pio_top_lines_oe_o,
    input wire logic [2:0]  converter_clock_out_sel_o,
    input wire logic        stereo_mode_o,
    input wire logic [1:0]  rate_o,
    input wire logic        monitor_16bit_o,
    input wire logic        frame_delay_en_o
);
    logic mode_hi_reg;
    logic mode_hi_next;
    logic wr_mode;
    logic wr_clk;
    logic any_lo;
    logic any_oe;
    assign wr_mode = cfg_wr_i && cfg_addr_i == 8'h7b;
    assign wr_clk  = cfg_wr_i && cfg_addr_i == 8'h60;
    assign any_lo  = |{pio_lines_low_group_oe_o, pio_mid_lines_oe_o, pio_top_lines_oe_o};
    assign any_oe  = any_lo || |pio_lines_high_group_oe_o;
    always_comb begin
        mode_hi_next = wr_mode ? cfg_data_i[4] : mode_hi_reg;
    end
    always_ff @(posedge mclk_i) begin
        mode_hi_reg <= nrst_i ? mode_hi_next : 1'b0;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // ==========
    // register decode
    property p_rate;
        logic [2:0] m;
        (wr_mode, m = cfg_data_i[2:0]) |=> rate_o == ((m == 3'h6) ? vei_pkg::SR_32K
            : vei_pkg::vei_rate_type'(m[2:1]));
    endproperty
    property p_stereo;
        logic [2:0] m;
        (wr_mode, m = cfg_data_i[2:0]) |=> stereo_mode_o == (!m[0] && m != 3'h6);
    endproperty
    property p_mon;
        logic v;
        (cfg_wr_i && cfg_addr_i == 8'h74, v = cfg_data_i[0]) |=> monitor_16bit_o == v;
    endproperty
    chk_mode_rate: assert property (p_rate)
        else $error("rate does not follow mode write");
    chk_mode_stereo: assert property (p_stereo)
        else $error("stereo flag does not follow mode write");
    chk_mon_width: assert property (p_mon)
        else $error("monitor width does not follow write");
    chk_no_delay: assert property (frame_delay_en_o == !monitor_16bit_o)
        else $error("frame delay active in 16-bit mode");
    chk_clk_full: assert property (wr_clk && cfg_data_i == 20'h10000 |=>
        converter_clock_out_sel_o == (rate_o == vei_pkg::SR_11K ? vei_pkg::CK_22579
        : vei_pkg::CK_24576)) else $error("fixed full clock wrong");
    chk_clk_half: assert property (wr_clk && cfg_data_i == 20'h20000 |=>
        converter_clock_out_sel_o == (rate_o == vei_pkg::SR_11K ? vei_pkg::CK_11290
        : vei_pkg::CK_12288)) else $error("fixed half clock wrong");
    chk_reset_vals: assert property ($rose(nrst_i) |-> rate_o == vei_pkg::SR_8K
        && stereo_mode_o && !monitor_16bit_o) else $error("register defaults wrong");
    // ==========
    // byte read handshake
    sequence s_sel_fall;
        $fell(parallel_select_n) && !byte_waiting_n;
    endsequence
    sequence s_drive;
        ##[1:8] any_oe;
    endsequence
    sequence s_idle4;
        parallel_select_n [*4];
    endsequence
    chk_sel_drive: assert property (s_sel_fall |-> s_drive)
        else $error("no byte driven after select fall");
    chk_sel_release: assert property ($rose(parallel_select_n) |-> ##[1:8] !any_oe)
        else $error("bus not released after select rise");
    chk_pin_group: assert property (any_oe |->
        (|pio_lines_high_group_oe_o) == mode_hi_reg && any_lo == !mode_hi_reg)
        else $error("byte on wrong pin group");
    chk_wait_hold: assert property (s_idle4 ##0 !byte_waiting_n |=> !byte_waiting_n)
        else $error("waiting flag rose without a read");
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the voice encoder i/o top
// drives register writes, a converter model on the link and the byte read handshake
`timescale 1ns/1ps
module tb_top;
    logic        mclk_i, nrst_i, cfg_wr_i, run_i, clock_scaler_strap;
    logic        link_nrst_i, parallel_select_n, byte_waiting_n, any_oe;
    logic [7:0]  cfg_addr_i, pio_lines_high_group_o, pio_lines_high_group_oe_o;
    logic [19:0] cfg_data_i;
    logic [5:0]  sample_word_len_i;
    logic [3:0]  pio_lines_low_group_o, pio_lines_low_group_oe_o;
    logic [1:0]  pio_mid_lines_o, pio_mid_lines_oe_o, pio_top_lines_o, pio_top_lines_oe_o;
    logic        serial_in_bit_clock, serial_in_frame_strobe, serial_in_sample_data;
    logic        stereo_mode_o, monitor_16bit_o, frame_delay_en_o, sample_overrun_o;
    vei_pkg::vei_clk_sel_type converter_clock_out_sel_o;
    vei_pkg::vei_rate_type    rate_o;
    int          num_errors, n_tests, hi_mode, ovr_seen, ri;
    logic [7:0]  exp_q[$];
    assign any_oe = |{pio_lines_low_group_oe_o, pio_lines_high_group_oe_o,
                      pio_mid_lines_oe_o, pio_top_lines_oe_o};
    vei_top DUT (.mclk_i, .nrst_i, .cfg_wr_i, .cfg_addr_i, .cfg_data_i, .run_i,
        .clock_scaler_strap, .sample_word_len_i, .serial_in_bit_clock, .link_nrst_i,
        .serial_in_frame_strobe, .serial_in_sample_data, .parallel_select_n,
        .byte_waiting_n, .pio_lines_low_group_o, .pio_lines_low_group_oe_o,
        .pio_lines_high_group_o, .pio_lines_high_group_oe_o, .pio_mid_lines_o,
        .pio_mid_lines_oe_o, .pio_top_lines_o, .pio_top_lines_oe_o,
        .converter_clock_out_sel_o, .stereo_mode_o, .rate_o, .monitor_16bit_o,
        .frame_delay_en_o, .sample_overrun_o);
    vei_conv_model conv (.sclk_o(serial_in_bit_clock), .ws_o(serial_in_frame_strobe),
        .sd_o(serial_in_sample_data));
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) if (sample_overrun_o === 1'b1) ovr_seen <= 1;
    // ==========
    // tasks
    task automatic check(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [19:0] d);
        tick(1);
        {cfg_wr_i, cfg_addr_i, cfg_data_i} = {1'b1, a, d};
        tick(1);
        cfg_wr_i = 1'b0;
        tick(1);
    endtask
    // link reset needs bit clock edges: a dummy pair runs during reset
    task automatic do_reset(input logic s);
        {nrst_i, link_nrst_i, clock_scaler_strap} = {2'b00, s};
        conv.send_pair(16'h0, 16'h0, 16);
        tick(1);
        {nrst_i, link_nrst_i} = 2'b11;
        exp_q.delete();
        tick(5);
    endtask
    task automatic pair(input logic [15:0] l, input logic [15:0] r, input int mi);
        int s;
        conv.send_pair(l, r, sample_word_len_i);
        s = mi == 0 ? l : mi == 1 ? l + r : mi == 2 ? (l + r) / 2 : (l + r) / 4;
        if (run_i && exp_q.size() < 32) exp_q.push_back(s[15:8]);
        tick(6);
    endtask
    task automatic rd();
        int k;
        logic [7:0] b;
        check("waiting", byte_waiting_n, 0);
        parallel_select_n = 1'b0;
        for (k = 0; k < 20 && any_oe !== 1'b1; k++) tick(1);
        b = hi_mode ? pio_lines_high_group_o
            : {pio_top_lines_o, pio_mid_lines_o, pio_lines_low_group_o};
        check("pin_oe", {pio_lines_high_group_oe_o, pio_top_lines_oe_o, pio_mid_lines_oe_o,
            pio_lines_low_group_oe_o}, hi_mode ? 16'hff00 : 16'h00ff);
        check("byte", b, exp_q.pop_front());
        parallel_select_n = 1'b1;
        for (k = 0; k < 20 && any_oe !== 1'b0; k++) tick(1);
        check("release", any_oe, 0);
        tick(2);
    endtask
    function automatic vei_pkg::vei_clk_sel_type eclk(input int r, input int c, input int s);
        if (c == 0 && s == 1) return r == 1 ? vei_pkg::CK_22579 : vei_pkg::CK_24576;
        if (c == 0) c = r == 3 ? 1 : r == 2 ? 2 : 3;
        if (r == 1) return c == 1 ? vei_pkg::CK_22579 : c == 2 ? vei_pkg::CK_11290
            : vei_pkg::CK_5645;
        return c == 1 ? vei_pkg::CK_24576 : c == 2 ? vei_pkg::CK_12288 : vei_pkg::CK_6144;
    endfunction
    // ==========
    // main sequence
    initial begin
        void'($urandom(27));
        {cfg_wr_i, cfg_addr_i, cfg_data_i, run_i, parallel_select_n} = 31'h1;
        sample_word_len_i = 6'h10;
        {num_errors, n_tests, hi_mode, ovr_seen} = '0;
        for (int s = 0; s < 2; s++) begin
            do_reset(s[0]);
            check("rst_rate", rate_o, vei_pkg::SR_8K);
            check("rst_mon", {stereo_mode_o, monitor_16bit_o}, 2'b10);
            for (int m = 0; m < 23; m++) begin
                if (m > 6 && m < 16) continue;
                wr(8'h7b, 20'(m));
                ri = (m % 8 == 6) ? 3 : (m % 8) / 2;
                check("rate", rate_o, 20'(ri));
                check("stereo", stereo_mode_o, m % 2 == 0 && m % 8 != 6);
                for (int c = 0; c < 4; c++) begin
                    wr(8'h60, c == 0 ? 20'h0 : 20'h10000 << (c - 1));
                    check("clk_sel", converter_clock_out_sel_o, eclk(ri, c, s));
                end
            end
        end
        for (int v = 0; v < 2; v++) begin
            wr(8'h74, 20'(v));
            check("mon16", {monitor_16bit_o, frame_delay_en_o}, v ? 2'b10 : 2'b01);
        end
        // unmapped offset is ignored
        wr(8'h62, 20'hfffff);
        check("unmapped", {rate_o, stereo_mode_o, monitor_16bit_o}, 4'b1101);
        for (int k = 0; k < 4; k++) begin
            wr(8'h61, k == 0 ? 20'h0 : 20'(8'h3f + k));
            hi_mode = k % 2;
            wr(8'h7b, hi_mode ? 20'h10 : 20'h0);
            run_i = 1'b1;
            repeat (3) pair(16'($urandom_range(16'h3fff)), 16'($urandom_range(16'h3fff)), k);
            run_i = 1'b0;
            repeat (3) rd();
            check("empty", byte_waiting_n, 1);
        end
        pair(16'h1234, 16'h0, 3);
        check("refused", byte_waiting_n, 1);
        wr(8'h61, 20'h0);
        run_i = 1'b1;
        repeat (34) begin
            sample_word_len_i = 6'(8 << $urandom_range(2));
            pair(16'($urandom_range(16'hffff)), 16'h0, 0);
        end
        run_i = 1'b0;
        check("overrun", ovr_seen, 1);
        repeat (32) rd();
        check("drained", byte_waiting_n, 1);
        summarize();
    end
endmodule
bind vei_top vei_top_props u_props (.mclk_i, .nrst_i, .cfg_wr_i, .cfg_addr_i, .cfg_data_i,
    .parallel_select_n, .byte_waiting_n, .pio_lines_low_group_oe_o,
    .pio_lines_high_group_oe_o, .pio_mid_lines_oe_o, .pio_top_lines_oe_o,
    .converter_clock_out_sel_o, .stereo_mode_o, .rate_o, .monitor_16bit_o,
    .frame_delay_en_o);
